// File: logic/sbr_phy_regs.sv
// Phy register bank: storage, status capture and read mux
`timescale 1ns/1ps
module sbr_phy_regs #(
    parameter int unsigned NUM_PORTS = 3,
    parameter logic [1:0]  TOP_SPEED = 2'h1
) (
    input  wire logic                         ref_clk,
    input  wire logic                         sys_rst,
    input  wire logic                         clk_en,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    input  wire logic [sbr_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [sbr_pkg::DATA_W-1:0]   reg_wdata,
    output logic      [sbr_pkg::DATA_W-1:0]   reg_rdata_q,
    output logic                              reg_rvalid_q,
    input  wire logic [5:0]                   node_identifier,
    input  wire logic                         is_root,
    input  wire logic [2*NUM_PORTS-1:0]       a_pair_line_state,
    input  wire logic [2*NUM_PORTS-1:0]       b_pair_line_state,
    input  wire logic [NUM_PORTS-1:0]         port_busy,
    input  wire logic [NUM_PORTS-1:0]         child_flag,
    input  wire logic [NUM_PORTS-1:0]         port_connected,
    input  wire logic                         tree_id_timeout,
    input  wire logic [NUM_PORTS-1:0]         waiting_ports,
    input  wire logic                         bus_reset_begin,
    input  wire logic                         cable_power_pin,
    input  wire logic                         short_reset_mode_pin,
    input  wire logic                         contender_pin,
    input  wire logic [2:0]                   power_class_pins,
    output logic                              root_holdoff_flag_q,
    output logic                              long_reset_request_q,
    output logic                              short_reset_request_q,
    output logic      [5:0]                   gap_setting_q,
    output logic                              local_reset_origin_q
);

    if (NUM_PORTS != 3) begin : g_bad_ports
        $error("sbr_phy_regs serves exactly three ports");
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: pins stem from outside the clock domain

    logic [sbr_pkg::SYNC_W-1:0] sync1_q;
    logic [sbr_pkg::SYNC_W-1:0] sync2_q;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_q <= sbr_pkg::SYNC_RESET;
            sync2_q <= sbr_pkg::SYNC_RESET;
        end else if (clk_en) begin
            sync1_q <= {power_class_pins, contender_pin,
                        short_reset_mode_pin, cable_power_pin};
            sync2_q <= sync1_q;
        end
    end

    logic       cable_power_s;
    logic       short_mode_n_s;
    logic       contender_s;
    logic [2:0] pclass_s;
    assign cable_power_s  = sync2_q[0];
    assign short_mode_n_s = sync2_q[1];
    assign contender_s    = sync2_q[2];
    assign pclass_s       = sync2_q[5:3];

    ////////////////////////////////////////////////////////////////////
    // Status capture, ports

    logic [5:0]           node_id_q;
    logic                 root_q;
    logic [2*NUM_PORTS-1:0] a_line_q;
    logic [2*NUM_PORTS-1:0] b_line_q;
    logic [NUM_PORTS-1:0] child_q;
    logic [NUM_PORTS-1:0] conn_q;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            node_id_q <= '0;
            root_q    <= 1'b0;
            child_q   <= '0;
            conn_q    <= '0;
        end else if (clk_en) begin
            node_id_q <= node_identifier;
            root_q    <= is_root;
            child_q   <= child_flag;
            conn_q    <= port_connected;
        end
    end

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_line
        logic [1:0] a_q;
        logic [1:0] b_q;
        always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
                a_q <= sbr_pkg::LINE_INVALID;
                b_q <= sbr_pkg::LINE_INVALID;
            end else if (clk_en) begin
                // Line code is meaningless while the port moves data
                if (port_busy[p]) begin
                    a_q <= sbr_pkg::LINE_INVALID;
                    b_q <= sbr_pkg::LINE_INVALID;
                end else begin
                    a_q <= a_pair_line_state[2*p +: 2];
                    b_q <= b_pair_line_state[2*p +: 2];
                end
            end
        end
        assign a_line_q[2*p +: 2] = a_q;
        assign b_line_q[2*p +: 2] = b_q;
    end

    ////////////////////////////////////////////////////////////////////
    // Write decode

    logic wr_rst_gap;
    logic wr_irq;
    logic wr_short;
    assign wr_rst_gap = clk_en && reg_wr
                        && (reg_addr == sbr_pkg::OFS_RST_GAP);
    assign wr_irq     = clk_en && reg_wr
                        && (reg_addr == sbr_pkg::OFS_IRQ);
    assign wr_short   = clk_en && reg_wr
                        && (reg_addr == sbr_pkg::OFS_SHORT);

    logic long_wr_set;
    logic short_wr_set;
    logic short_as_long;
    assign long_wr_set   = wr_rst_gap
                           && reg_wdata[sbr_pkg::BIT_LONG_RESET];
    assign short_wr_set  = wr_short
                           && reg_wdata[sbr_pkg::BIT_SHORT_RESET];
    // Pin high means legacy mode: a short request turns into long
    assign short_as_long = short_wr_set && short_mode_n_s;

    ////////////////////////////////////////////////////////////////////
    // Reset control and gap

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            root_holdoff_flag_q <= 1'b0;
            gap_setting_q       <= sbr_pkg::GAP_RESET;
        end else if (wr_rst_gap) begin
            root_holdoff_flag_q <=
                reg_wdata[sbr_pkg::BIT_ROOT_HOLDOFF];
            gap_setting_q <= reg_wdata[5:0];
        end
    end

    // Requests stand until the core begins a reset, the short one also until the mode pin goes high; a new write wins
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            long_reset_request_q <= 1'b0;
        end else if (clk_en) begin
            if (long_wr_set || short_as_long) begin
                long_reset_request_q <= 1'b1;
            end else if (bus_reset_begin) begin
                long_reset_request_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            short_reset_request_q <= 1'b0;
        end else if (clk_en) begin
            if (short_wr_set && !short_mode_n_s) begin
                short_reset_request_q <= 1'b1;
            end else if (bus_reset_begin || short_mode_n_s) begin
                short_reset_request_q <= 1'b0;
            end
        end
    end

    // Origin flag follows the source of each reset as it begins
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            local_reset_origin_q <= 1'b0;
        end else if (clk_en) begin
            if (bus_reset_begin) begin
                local_reset_origin_q <= long_reset_request_q
                    || short_reset_request_q;
            end else if (wr_irq) begin
                local_reset_origin_q <=
                    reg_wdata[sbr_pkg::BIT_ORIGIN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Event flags: a set in the clearing cycle wins

    logic loop_q;
    logic pdrop_q;
    logic loop_set;
    assign loop_set = tree_id_timeout
                      && ($countones(waiting_ports) >= 2);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            loop_q <= 1'b0;
        end else if (clk_en) begin
            if (loop_set) begin
                loop_q <= 1'b1;
            end else if (wr_irq && !reg_wdata[sbr_pkg::BIT_LOOP]) begin
                loop_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pdrop_q <= 1'b0;
        end else if (clk_en) begin
            // Level set, so a clear during low power cannot stick
            if (!cable_power_s) begin
                pdrop_q <= 1'b1;
            end else if (wr_irq && !reg_wdata[sbr_pkg::BIT_PDROP]) begin
                pdrop_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux

    function automatic logic [7:0] port_byte(input int unsigned p);
        return {a_line_q[2*p +: 2], b_line_q[2*p +: 2],
                child_q[p], conn_q[p], 2'h0};
    endfunction

    function automatic logic [7:0] read_mux(
        input logic [sbr_pkg::ADDR_W-1:0] a);
        case (a)
            sbr_pkg::OFS_ID_ROOT:
                read_mux = {node_id_q, root_q, cable_power_s};
            sbr_pkg::OFS_RST_GAP:
                read_mux = {root_holdoff_flag_q, long_reset_request_q,
                            gap_setting_q};
            sbr_pkg::OFS_SPEED:
                read_mux = {TOP_SPEED, 2'h0,
                            sbr_pkg::PORT_COUNT};
            sbr_pkg::OFS_PORT1: read_mux = port_byte(0);
            sbr_pkg::OFS_PORT2: read_mux = port_byte(1);
            sbr_pkg::OFS_PORT3: read_mux = port_byte(2);
            sbr_pkg::OFS_IRQ:
                read_mux = {loop_q, pdrop_q, cable_power_s,
                            local_reset_origin_q, 4'h0};
            sbr_pkg::OFS_PCLASS:
                read_mux = {4'h0, contender_s,
                            pclass_s};
            sbr_pkg::OFS_SHORT:
                read_mux = {7'h00, short_reset_request_q};
            default:
                read_mux = sbr_pkg::DATA_ZERO;
        endcase
    endfunction

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_q  <= sbr_pkg::DATA_ZERO;
            reg_rvalid_q <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid_q <= reg_rd;
            if (reg_rd) begin
                reg_rdata_q <= read_mux(reg_addr);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_rd(logic [3:0] a);
        clk_en && reg_rd && reg_addr == a;
    endsequence

    sequence s_short_legacy;
        short_wr_set && short_mode_n_s;
    endsequence

    sequence s_power_low;
        clk_en && !cable_power_s;
    endsequence

    a_id_root_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_rd(sbr_pkg::OFS_ID_ROOT) |=> reg_rvalid_q
        && reg_rdata_q == {$past(node_id_q), $past(root_q),
                           $past(cable_power_s)})
        else $error("register 0 read data wrong");

    a_port_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_rd(sbr_pkg::OFS_SPEED) |=> reg_rdata_q[3:0] == 4'h3
        && reg_rdata_q[7:6] == TOP_SPEED)
        else $error("port count or speed wrong");

    a_busy_invalid: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && port_busy[0] |=> a_line_q[1:0] == 2'h0
        && b_line_q[1:0] == 2'h0)
        else $error("busy port line state not invalid");

    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_rd(sbr_pkg::OFS_RSVD8) |=> reg_rdata_q == 8'h00)
        else $error("reserved register not zero");

    a_pdrop_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_power_low [*2] |-> pdrop_q ##1 pdrop_q)
        else $error("power drop flag not held while power low");

    a_loop_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && tree_id_timeout && waiting_ports == 3'h3
        |=> loop_q)
        else $error("loop flag not set");

    a_long_req: assert property (@(posedge ref_clk) disable iff (sys_rst)
        long_wr_set |=> long_reset_request_q)
        else $error("long reset request not taken");

    a_short_legacy: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_short_legacy |=> long_reset_request_q
        && !short_reset_request_q)
        else $error("short reset in legacy mode");

    a_gap_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_rst_gap |=> gap_setting_q == $past(reg_wdata[5:0]))
        else $error("gap setting not stored");

    a_origin_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && bus_reset_begin && long_reset_request_q
        |=> local_reset_origin_q)
        else $error("origin flag missed local reset");

    a_short_drop: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && short_mode_n_s |=> !short_reset_request_q)
        else $error("short reset request kept in legacy mode");

    a_loop_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_irq && !reg_wdata[sbr_pkg::BIT_LOOP] && !loop_set
        |=> !loop_q)
        else $error("loop flag not cleared by write");

    a_pdrop_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_irq && !reg_wdata[sbr_pkg::BIT_PDROP] && cable_power_s
        |=> !pdrop_q)
        else $error("power drop flag not cleared by write");

    a_long_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && bus_reset_begin && !long_wr_set && !short_as_long
        |=> !long_reset_request_q)
        else $error("long reset request not dropped at reset");

endmodule // sbr_phy_regs

// File: logic/sbr_pkg.sv
// Constants for the serial bus phy register bank
// What this block does
// - Read-only 6-bit node identifier from self-identification.
// - Register 0 holds read-only root flag, set when node is root.
// - Register 0 bit 7, counted msb first, is read-only cable power flag.
// - Writable root hold-off flag makes node try for root next reset.
// - Writing one to long reset request starts bus reset next chance.
// - Register 1 holds 6-bit read/write gap setting.
// - Read-only 2-bit top speed code of the local ports.
// - Read-only 4-bit port count always reads 0011.
// - A-pair line state: 11 Z, 01 one, 10 zero, 00 invalid.
// - Line states reset to 00 and read 00 while port is busy.
// - Each port reports B-pair line state with same encoding.
// - Child flag reads one for child port, zero for parent port.
// - Connected flag reads one when a cable is present on port.
// - Loop flag sets on tree timeout waiting on two or more ports.
// - Writing zero clears loop flag; it resets if loop persists.
// - Power drop flag sets when cable power falls too low.
// - Writing zero clears power drop flag; low power resets it at once.
// - Register 6 carries a second copy of the cable power flag.
// - Local reset origin flag marks resets started here; sent in self-id.
// - Read-only manager contender flag reads one for candidate nodes.
// - Three read-only power class bits, msb, middle, lsb in order.
// - Writing one to short reset request starts arbitrated short reset.
// - Short request works only with mode pin low; else long reset.
// - Power drop flag is also cleared by hardware reset.
package sbr_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam logic [3:0] OFS_ID_ROOT = 4'h0;
    localparam logic [3:0] OFS_RST_GAP = 4'h1;
    localparam logic [3:0] OFS_SPEED   = 4'h2;
    localparam logic [3:0] OFS_PORT1   = 4'h3;
    localparam logic [3:0] OFS_PORT2   = 4'h4;
    localparam logic [3:0] OFS_PORT3   = 4'h5;
    localparam logic [3:0] OFS_IRQ     = 4'h6;
    localparam logic [3:0] OFS_PCLASS  = 4'h7;
    localparam logic [3:0] OFS_RSVD8   = 4'h8;
    localparam logic [3:0] OFS_SHORT   = 4'h9;
    // Bit positions: fields count msb first, so field bit 0 is data bit 7
    localparam int unsigned BIT_ROOT_HOLDOFF = 7;
    localparam int unsigned BIT_LONG_RESET  = 6;
    localparam int unsigned BIT_LOOP        = 7;
    localparam int unsigned BIT_PDROP       = 6;
    localparam int unsigned BIT_ORIGIN      = 4;
    localparam int unsigned BIT_SHORT_RESET = 0;
    localparam logic [3:0] PORT_COUNT = 4'h3;
    localparam logic [1:0] LINE_INVALID = 2'h0;
    localparam logic [1:0] LINE_ONE     = 2'h1;
    localparam logic [1:0] LINE_ZERO    = 2'h2;
    localparam logic [1:0] LINE_Z       = 2'h3;
    localparam logic [5:0] GAP_RESET    = 6'h3f;
    localparam logic [7:0] DATA_ZERO    = 8'h00;
    localparam int unsigned SYNC_W = 6;
    // Power present, legacy mode: no false power drop event after reset
    localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h03;
endpackage

// File: tb/sbr_llc_model.sv
// Link controller model driving the phy register strobe port
`timescale 1ns/1ps
module sbr_llc_model (
    input  wire logic                       ref_clk,
    output logic                            reg_wr,
    output logic                            reg_rd,
    output logic [sbr_pkg::ADDR_W-1:0]      reg_addr,
    output logic [sbr_pkg::DATA_W-1:0]      reg_wdata,
    input  wire logic [sbr_pkg::DATA_W-1:0] reg_rdata_q,
    input  wire logic                       reg_rvalid_q
);
    int idle = 0;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
    end
    // Released lines toggle so a stale address or byte is never reused
    task automatic release_bus();
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        repeat (idle) @(posedge ref_clk);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        release_bus();
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d,
                      output logic ok);
        repeat (idle) @(posedge ref_clk);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk);
        #1;
        release_bus();
        ok = reg_rvalid_q;
        d = reg_rdata_q;
    endtask
endmodule // sbr_llc_model

// File: tb/tb_top.sv
// Self-checking bench for the phy register bank
`timescale 1ns/1ps
module tb_top;
    logic       ref_clk, sys_rst, clk_en, reg_wr, reg_rd, reg_rvalid_q;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata_q;
    logic [5:0] node_identifier, a_line, b_line, gap_setting_q;
    logic [2:0] port_busy, child_flag, port_connected, waiting_ports;
    logic [2:0] power_class_pins;
    logic       is_root, tree_id_timeout, bus_reset_begin, cable_power_pin;
    logic       short_reset_mode_pin, contender_pin, root_holdoff_flag_q;
    logic       long_reset_request_q, short_reset_request_q;
    logic       local_reset_origin_q;
    int         fail_count = 0;
    int         n_tests = 0;
    int         cycles = 0;
    sbr_phy_regs u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
        .node_identifier(node_identifier), .is_root(is_root),
        .a_pair_line_state(a_line), .b_pair_line_state(b_line),
        .port_busy(port_busy), .child_flag(child_flag),
        .port_connected(port_connected),
        .tree_id_timeout(tree_id_timeout), .waiting_ports(waiting_ports),
        .bus_reset_begin(bus_reset_begin),
        .cable_power_pin(cable_power_pin),
        .short_reset_mode_pin(short_reset_mode_pin),
        .contender_pin(contender_pin), .power_class_pins(power_class_pins),
        .root_holdoff_flag_q(root_holdoff_flag_q),
        .long_reset_request_q(long_reset_request_q),
        .short_reset_request_q(short_reset_request_q),
        .gap_setting_q(gap_setting_q),
        .local_reset_origin_q(local_reset_origin_q));
    sbr_llc_model u_llc (.ref_clk(ref_clk), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q));
    ////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdchk(input string what, input logic [3:0] a,
                         input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        u_llc.rd(a, d, ok);
        chk({what, " valid"}, 8'h01, {7'h00, ok});
        chk(what, exp, d);
    endtask
    task automatic pulse_reset_begin();
        bus_reset_begin = 1'b1;
        tick(1);
        bus_reset_begin = 1'b0;
        tick(1);
    endtask
    task automatic pulse_timeout(input logic [2:0] w);
        waiting_ports = w;
        tree_id_timeout = 1'b1;
        tick(1);
        tree_id_timeout = 1'b0;
        tick(2);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_identity();
        node_identifier = 6'h2a;
        is_root = 1'b1;
        tick(4);
        rdchk("id root power", sbr_pkg::OFS_ID_ROOT, 8'hab);
        rdchk("speed ports", sbr_pkg::OFS_SPEED, 8'h43);
        contender_pin = 1'b1;
        power_class_pins = 3'b100;
        tick(4);
        rdchk("pclass a", sbr_pkg::OFS_PCLASS, 8'h0c);
        contender_pin = 1'b0;
        power_class_pins = 3'b011;
        tick(4);
        rdchk("pclass b", sbr_pkg::OFS_PCLASS, 8'h03);
    endtask
    task automatic t_power();
        cable_power_pin = 1'b0;
        is_root = 1'b0;
        tick(4);
        rdchk("power low r0", sbr_pkg::OFS_ID_ROOT, 8'ha8);
        rdchk("pdrop set", sbr_pkg::OFS_IRQ, 8'h40);
        u_llc.wr(sbr_pkg::OFS_IRQ, 8'h00);
        rdchk("pdrop back", sbr_pkg::OFS_IRQ, 8'h40);
        cable_power_pin = 1'b1;
        tick(4);
        u_llc.wr(sbr_pkg::OFS_IRQ, 8'h80);
        rdchk("pdrop clear", sbr_pkg::OFS_IRQ, 8'h20);
    endtask
    task automatic t_loop();
        pulse_timeout(3'b001);
        rdchk("loop one port", sbr_pkg::OFS_IRQ, 8'h20);
        pulse_timeout(3'b110);
        rdchk("loop set", sbr_pkg::OFS_IRQ, 8'ha0);
        u_llc.wr(sbr_pkg::OFS_IRQ, 8'h40);
        rdchk("loop clear", sbr_pkg::OFS_IRQ, 8'h20);
        pulse_timeout(3'b011);
        rdchk("loop again", sbr_pkg::OFS_IRQ, 8'ha0);
        u_llc.wr(sbr_pkg::OFS_IRQ, 8'h40);
    endtask
    task automatic t_ports();
        logic [7:0] e;
        logic [3:0] a;
        a_line = {sbr_pkg::LINE_ZERO, sbr_pkg::LINE_ONE, sbr_pkg::LINE_Z};
        b_line = {sbr_pkg::LINE_Z, sbr_pkg::LINE_ZERO, sbr_pkg::LINE_ONE};
        child_flag = 3'b101;
        port_connected = 3'b011;
        for (int i = 0; i < 2; i++) begin
            port_busy = i[0] ? 3'b010 : 3'b000;
            tick(3);
            for (int p = 0; p < 3; p++) begin
                e = {a_line[2*p+:2], b_line[2*p+:2], child_flag[p],
                     port_connected[p], 2'b00};
                // A busy port reports the invalid code on both pairs
                if (port_busy[p]) e[7:4] = 4'h0;
                a = sbr_pkg::OFS_PORT1 + 4'(p);
                rdchk("port", a, e);
            end
        end
    endtask
    task automatic t_resets();
        u_llc.wr(sbr_pkg::OFS_RST_GAP, 8'h95);
        rdchk("holdoff gap", sbr_pkg::OFS_RST_GAP, 8'h95);
        chk("holdoff out", 8'h01, {7'h00, root_holdoff_flag_q});
        chk("gap out", 8'h15, {2'b00, gap_setting_q});
        u_llc.wr(sbr_pkg::OFS_RST_GAP, 8'h55);
        chk("long req", 8'h01, {7'h00, long_reset_request_q});
        pulse_reset_begin();
        chk("long done", 8'h00, {7'h00, long_reset_request_q});
        chk("origin", 8'h01, {7'h00, local_reset_origin_q});
        rdchk("origin r6", sbr_pkg::OFS_IRQ, 8'h30);
        short_reset_mode_pin = 1'b0;
        tick(4);
        u_llc.wr(sbr_pkg::OFS_SHORT, 8'h01);
        chk("short req", 8'h01, {7'h00, short_reset_request_q});
        rdchk("short r9", sbr_pkg::OFS_SHORT, 8'h01);
        pulse_reset_begin();
        chk("short done", 8'h00, {7'h00, short_reset_request_q});
        pulse_reset_begin();
        chk("origin off", 8'h00, {7'h00, local_reset_origin_q});
        short_reset_mode_pin = 1'b1;
        tick(4);
        u_llc.wr(sbr_pkg::OFS_SHORT, 8'h01);
        chk("short blocked", 8'h00, {7'h00, short_reset_request_q});
        chk("long instead", 8'h01, {7'h00, long_reset_request_q});
        pulse_reset_begin();
    endtask
    task automatic t_reserved();
        u_llc.wr(sbr_pkg::OFS_RSVD8, 8'hff);
        rdchk("reg8", sbr_pkg::OFS_RSVD8, 8'h00);
        u_llc.wr(sbr_pkg::OFS_SPEED, 8'hff);
        rdchk("ro speed", sbr_pkg::OFS_SPEED, 8'h43);
        u_llc.wr(sbr_pkg::OFS_SHORT, 8'hfe);
        rdchk("r9 spare", sbr_pkg::OFS_SHORT, 8'h00);
        rdchk("unmapped", 4'hc, 8'h00);
        clk_en = 1'b0;
        u_llc.wr(sbr_pkg::OFS_RST_GAP, 8'h00);
        clk_en = 1'b1;
        u_llc.idle = 2;
        rdchk("frozen gap", sbr_pkg::OFS_RST_GAP, 8'h15);
        // Leave the drop flag set so the reset has something to clear
        cable_power_pin = 1'b0;
        tick(4);
        cable_power_pin = 1'b1;
        sys_rst = 1'b1;
        tick(2);
        chk("gap reset", {2'b00, sbr_pkg::GAP_RESET},
            {2'b00, gap_setting_q});
        sys_rst = 1'b0;
        rdchk("pdrop reset", sbr_pkg::OFS_IRQ, 8'h20);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        {sys_rst, clk_en, is_root, cable_power_pin} = 4'hd;
        {tree_id_timeout, bus_reset_begin, contender_pin} = 3'h0;
        short_reset_mode_pin = 1'b1;
        {node_identifier, a_line, b_line} = 18'h0;
        {port_busy, child_flag, port_connected} = 9'h0;
        {waiting_ports, power_class_pins} = 6'h0;
        repeat (20) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        rdchk("gap after reset", sbr_pkg::OFS_RST_GAP, 8'h3f);
        t_identity();
        t_power();
        t_loop();
        t_ports();
        t_resets();
        t_reserved();
        summarize();
    end
endmodule // tb_top
